// ### shared/osc_cfg_defines.svh
// Offsets, field positions, reset values and timing counts of the oscillator control block
`ifndef OSC_CFG_DEFINES_SVH
`define OSC_CFG_DEFINES_SVH
`define OFF_CTRL 12'h000
`define OFF_CMD 12'h004
`define OFF_STATUS 12'h008
`define CTRL_LFMODE_HI 12
`define CTRL_LFMODE_LO 11
`define CTRL_HFTO_HI 10
`define CTRL_HFTO_LO 9
`define CTRL_GLITCH_BIT 7
`define CTRL_BUFCUR_HI 6
`define CTRL_BUFCUR_LO 5
`define CTRL_BOOST_HI 3
`define CTRL_BOOST_LO 2
`define CTRL_HFMODE_HI 1
`define CTRL_HFMODE_LO 0
`define CMD_HF_EN_BIT 0
`define CMD_HF_DIS_BIT 1
`define CMD_LF_EN_BIT 6
`define CMD_LF_DIS_BIT 7
`define RST_LFMODE 2'h0
`define RST_HFTO 2'h3
`define RST_GLITCH 1'h0
`define RST_BUFCUR 2'h1
`define RST_BOOST 2'h3
`define RST_HFMODE 2'h0
`define TO_CYC0 15'h0008
`define TO_CYC1 15'h0100
`define TO_CYC2 15'h0400
`define TO_CYC3 15'h4000
`endif

// ### shared/osc_cfg_pkg.sv
// Types shared by the oscillator control block
package osc_cfg_pkg;
  typedef enum logic [1:0] {
    crystal_source = 2'h0,
    buffered_sine_input = 2'h1,
    digital_bypass_input = 2'h2,
    mode_unused = 2'h3
  } src_mode_t;

  typedef struct packed {
    logic [1:0] lfMode;
    logic [1:0] hfTimeout;
    logic glitchEn;
    logic [1:0] bufCur;
    logic [1:0] boost;
    logic [1:0] hfMode;
  } ctrl_fields_t;

  typedef struct packed {
    logic hfRunning;
    logic hfReady;
    logic lfRunning;
  } osc_status_t;
endpackage : osc_cfg_pkg

// ### rtl/pin_sync.sv
// Two flip-flop synchroniser for an oscillator-side level
`timescale 1ns/10ps
module pin_sync (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout
);
  logic meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : pin_sync

// ### rtl/startup_counter.sv
// Start-up counter with glitch restart for the high-frequency oscillator
`timescale 1ns/10ps
`include "osc_cfg_defines.svh"
module startup_counter (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic stop,
  input wire logic oscTick,
  input wire logic glitch,
  input wire logic glitchEn,
  input wire logic [1:0] timeoutSel,
  output logic ready
);
  logic [14:0] cnt_r;
  logic running_r;

  // Timeout in oscillator cycles per code
  // cycles per code
  function automatic logic [14:0] limitOf(input logic [1:0] sel);
    case (sel)
      2'h0: limitOf = `TO_CYC0;
      2'h1: limitOf = `TO_CYC1;
      2'h2: limitOf = `TO_CYC2;
      default: limitOf = `TO_CYC3;
    endcase
  endfunction : limitOf

  // Counter runs until the limit; glitches only matter while running
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 15'h0000;
      running_r <= 1'b0;
      ready <= 1'b0;
    end else if (stop) begin
      cnt_r <= 15'h0000;
      running_r <= 1'b0;
      ready <= 1'b0;
    end else if (start) begin
      cnt_r <= 15'h0000;
      running_r <= 1'b1;
      ready <= 1'b0;
    end else if (running_r && glitchEn && glitch) begin
      cnt_r <= 15'h0000;
    end else if (running_r && oscTick) begin
      if (cnt_r == limitOf(timeoutSel) - 15'h0001) begin
        running_r <= 1'b0;
        ready <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 15'h0001;
      end
    end
  end

  AST_NO_GLITCH_AFTER: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ready && !start && !stop |=> ready)
    else $error("ready dropped without command");

  AST_GLITCH_CLEAR: assert property (@(posedge clk_sys) disable iff (sys_rst)
    running_r && glitchEn && glitch && !start && !stop |=> cnt_r == 15'h0000 && !ready)
    else $error("glitch did not restart count");
endmodule : startup_counter

// ### rtl/osc_config_ctrl.sv
// Crystal oscillator configuration block with APB register slave
`timescale 1ns/10ps
`include "osc_cfg_defines.svh"

module osc_config_ctrl (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hfOscClkPin,
  input wire logic hfGlitchPin,
  output logic hfOscEnable,
  output logic [1:0] hfActiveMode,
  output logic hfCrystalOn,
  output logic hfSineBufOn,
  output logic hfBypassOn,
  output logic [1:0] hfBoostCurrent,
  output logic [1:0] hfBufferCurrent,
  output logic hfReady,
  output logic lfOscEnable,
  output logic [1:0] lfActiveMode,
  output logic lfCrystalOn,
  output logic lfSineBufOn,
  output logic lfBypassOn
);
  osc_cfg_pkg::ctrl_fields_t ctrl_r;
  osc_cfg_pkg::osc_status_t stat;
  logic wrEn;
  logic rdEn;
  logic addrOk;
  logic [31:0] cmdWord;
  logic hfEnCmd;
  logic hfDisCmd;
  logic lfEnCmd;
  logic lfDisCmd;
  logic oscClkSync;
  logic oscClkPrev_r;
  logic oscTick;
  logic glitchSync;
  logic glitchPrev_r;
  logic glitchPulse;

  // Source decode, shared by both oscillators
  function automatic logic [2:0] decodeMode(input logic [1:0] m);
    case (osc_cfg_pkg::src_mode_t'(m))
      osc_cfg_pkg::crystal_source: decodeMode = 3'h1;
      osc_cfg_pkg::buffered_sine_input: decodeMode = 3'h2;
      osc_cfg_pkg::digital_bypass_input: decodeMode = 3'h4;
      default: decodeMode = 3'h0;
    endcase
  endfunction : decodeMode

  // APB decode; zero wait states, unmapped addresses error
  assign addrOk = (paddr == `OFF_CTRL) || (paddr == `OFF_CMD) || (paddr == `OFF_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk;
  assign wrEn = psel && penable && pwrite && addrOk;
  assign rdEn = psel && !penable && !pwrite;
  assign cmdWord = (wrEn && paddr == `OFF_CMD) ? pwdata : 32'h0000_0000;
  assign hfEnCmd = cmdWord[`CMD_HF_EN_BIT];
  assign hfDisCmd = cmdWord[`CMD_HF_DIS_BIT];
  assign lfEnCmd = cmdWord[`CMD_LF_EN_BIT];
  assign lfDisCmd = cmdWord[`CMD_LF_DIS_BIT];

  // Control fields; buffer current is writable but calibrated, keep it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r.lfMode <= `RST_LFMODE;
      ctrl_r.hfTimeout <= `RST_HFTO;
      ctrl_r.glitchEn <= `RST_GLITCH;
      ctrl_r.bufCur <= `RST_BUFCUR;
      ctrl_r.boost <= `RST_BOOST;
      ctrl_r.hfMode <= `RST_HFMODE;
    end else begin
      if (wrEn && paddr == `OFF_CTRL) begin
        ctrl_r.lfMode <= pwdata[`CTRL_LFMODE_HI:`CTRL_LFMODE_LO];
        ctrl_r.hfTimeout <= pwdata[`CTRL_HFTO_HI:`CTRL_HFTO_LO];
        ctrl_r.glitchEn <= pwdata[`CTRL_GLITCH_BIT];
        ctrl_r.bufCur <= pwdata[`CTRL_BUFCUR_HI:`CTRL_BUFCUR_LO];
        ctrl_r.boost <= pwdata[`CTRL_BOOST_HI:`CTRL_BOOST_LO];
        ctrl_r.hfMode <= pwdata[`CTRL_HFMODE_HI:`CTRL_HFMODE_LO];
      end
      if (lfDisCmd) begin
        ctrl_r.lfMode <= `RST_LFMODE;
      end
      if (hfDisCmd) begin
        ctrl_r.hfMode <= `RST_HFMODE;
      end
    end
  end

  // Applied HF mode and enable; disable wins over enable in one write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hfActiveMode <= `RST_HFMODE;
      hfOscEnable <= 1'b0;
    end else if (hfDisCmd) begin
      hfActiveMode <= `RST_HFMODE;
      hfOscEnable <= 1'b0;
    end else if (hfEnCmd) begin
      hfActiveMode <= ctrl_r.hfMode;
      hfOscEnable <= 1'b1;
    end
  end

  // Applied LF mode and enable
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lfActiveMode <= `RST_LFMODE;
      lfOscEnable <= 1'b0;
    end else if (lfDisCmd) begin
      lfActiveMode <= `RST_LFMODE;
      lfOscEnable <= 1'b0;
    end else if (lfEnCmd) begin
      lfActiveMode <= ctrl_r.lfMode;
      lfOscEnable <= 1'b1;
    end
  end

  // Source selects and analog settings, registered
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      {hfBypassOn, hfSineBufOn, hfCrystalOn} <= 3'h0;
      {lfBypassOn, lfSineBufOn, lfCrystalOn} <= 3'h0;
      hfBoostCurrent <= `RST_BOOST;
      hfBufferCurrent <= `RST_BUFCUR;
    end else begin
      {hfBypassOn, hfSineBufOn, hfCrystalOn} <= hfOscEnable ? decodeMode(hfActiveMode) : 3'h0;
      {lfBypassOn, lfSineBufOn, lfCrystalOn} <= lfOscEnable ? decodeMode(lfActiveMode) : 3'h0;
      hfBoostCurrent <= ctrl_r.boost;
      hfBufferCurrent <= ctrl_r.bufCur;
    end
  end

  // Oscillator pins are asynchronous; slow clock only, edge taken after sync
  pin_sync uSyncClk (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .din(hfOscClkPin),
    .dout(oscClkSync)
  );

  pin_sync uSyncGlitch (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .din(hfGlitchPin),
    .dout(glitchSync)
  );

  // Edge detectors on synchronised levels
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      oscClkPrev_r <= 1'b0;
      glitchPrev_r <= 1'b0;
    end else begin
      oscClkPrev_r <= oscClkSync;
      glitchPrev_r <= glitchSync;
    end
  end

  assign oscTick = oscClkSync && !oscClkPrev_r;
  assign glitchPulse = glitchSync && !glitchPrev_r;

  startup_counter uStartup (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(hfEnCmd && !hfDisCmd),
    .stop(hfDisCmd),
    .oscTick(oscTick),
    .glitch(glitchPulse),
    .glitchEn(ctrl_r.glitchEn),
    .timeoutSel(ctrl_r.hfTimeout),
    .ready(hfReady)
  );

  assign stat.hfRunning = hfOscEnable;
  assign stat.hfReady = hfReady;
  assign stat.lfRunning = lfOscEnable;

  // Read data registered in setup phase; reserved bits read zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      case (paddr)
        `OFF_CTRL: prdata <= {19'h0, ctrl_r.lfMode, ctrl_r.hfTimeout, 1'b0, ctrl_r.glitchEn,
                              ctrl_r.bufCur, 1'b0, ctrl_r.boost, ctrl_r.hfMode};
        `OFF_STATUS: prdata <= {29'h0, stat};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  AST_HF_APPLY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hfEnCmd && !hfDisCmd |=> hfActiveMode == $past(ctrl_r.hfMode) && hfOscEnable)
    else $error("HF mode not applied on enable");

  AST_HF_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !hfEnCmd && !hfDisCmd |=> $stable(hfActiveMode) && $stable(hfOscEnable))
    else $error("HF mode changed without command");

  AST_HF_DIS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hfDisCmd |=> ctrl_r.hfMode == `RST_HFMODE && !hfOscEnable && !hfReady)
    else $error("HF disable did not restore default");

  // disable write; selects drop one cycle after the mode
  sequence hfDisWrite;
    wrEn && paddr == `OFF_CMD && pwdata[`CMD_HF_DIS_BIT];
  endsequence

  sequence hfSettledOff;
    (!hfOscEnable && hfActiveMode == `RST_HFMODE)
      ##1 (!hfCrystalOn && !hfSineBufOn && !hfBypassOn);
  endsequence

  AST_HF_OFF_SEQ: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hfDisWrite |=> hfSettledOff)
    else $error("HF outputs still on after disable");

  AST_LF_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !lfEnCmd && !lfDisCmd |=> $stable(lfActiveMode))
    else $error("LF mode changed without command");

  AST_LF_APPLY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    lfEnCmd && !lfDisCmd |=> lfActiveMode == $past(ctrl_r.lfMode) && lfOscEnable)
    else $error("LF mode not applied on enable");

  // enable write without disable in the same word
  sequence lfEnWrite;
    wrEn && paddr == `OFF_CMD && pwdata[`CMD_LF_EN_BIT] && !pwdata[`CMD_LF_DIS_BIT];
  endsequence

  // Mode 3 decodes to no source, so the second step lets it through
  sequence lfSettledOn;
    lfOscEnable
      ##1 (lfCrystalOn || lfSineBufOn || lfBypassOn || $past(lfActiveMode) == 2'h3);
  endsequence

  AST_LF_ON_SEQ: assert property (@(posedge clk_sys) disable iff (sys_rst)
    lfEnWrite |=> lfSettledOn)
    else $error("LF source not switched on after enable");

  AST_LF_DIS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    lfDisCmd |=> lfActiveMode == `RST_LFMODE && ctrl_r.lfMode == `RST_LFMODE)
    else $error("LF disable did not restore default");

  AST_LF_DECODE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    lfOscEnable && lfActiveMode == 2'h2 |=> lfBypassOn && !lfCrystalOn)
    else $error("LF decode wrong");

  AST_LF_DECODE_SINE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    lfOscEnable && lfActiveMode == 2'h1 |=> lfSineBufOn && !lfCrystalOn && !lfBypassOn)
    else $error("LF sine decode wrong");

  AST_HF_DECODE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hfOscEnable && hfActiveMode == 2'h1 |=> hfSineBufOn && !hfBypassOn)
    else $error("HF decode wrong");

  AST_HF_DECODE_CRYSTAL_SOURCE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hfOscEnable && hfActiveMode == 2'h0 |=> hfCrystalOn && !hfSineBufOn && !hfBypassOn)
    else $error("HF crystal decode wrong");

  AST_READY_LATE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hfEnCmd && !hfDisCmd |=> !hfReady [*8])
    else $error("ready came too soon");

  // ready rises only on a tick
  AST_READY_ON_TICK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !hfReady && !oscTick |=> !hfReady)
    else $error("ready rose without an oscillator edge");

  AST_TO_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wrEn && paddr == `OFF_CTRL |=> ctrl_r.hfTimeout == $past(pwdata[`CTRL_HFTO_HI:`CTRL_HFTO_LO]))
    else $error("timeout field not written");

  AST_BOOST_FOLLOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
    1'b1 |=> hfBoostCurrent == $past(ctrl_r.boost) && hfBufferCurrent == $past(ctrl_r.bufCur))
    else $error("analog settings do not follow fields");
endmodule : osc_config_ctrl

// ### verif/osc_config_ctrl_test.sv
// Self-checking testbench for the oscillator configuration block
`timescale 1ns/10ps
`include "osc_cfg_defines.svh"
module osc_config_ctrl_test;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic hfOscClkPin = 1'b0;
  logic hfGlitchPin = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, hfOscEnable, hfCrystalOn, hfSineBufOn, hfBypassOn, hfReady;
  logic lfOscEnable, lfCrystalOn, lfSineBufOn, lfBypassOn;
  logic [1:0] hfActiveMode, hfBoostCurrent, hfBufferCurrent, lfActiveMode;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int checks = 0;

  // Free-running system clock, 100 MHz
  always #5 clk_sys = ~clk_sys;

  osc_config_ctrl u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hfOscClkPin(hfOscClkPin),
    .hfGlitchPin(hfGlitchPin), .hfOscEnable(hfOscEnable), .hfActiveMode(hfActiveMode),
    .hfCrystalOn(hfCrystalOn), .hfSineBufOn(hfSineBufOn), .hfBypassOn(hfBypassOn),
    .hfBoostCurrent(hfBoostCurrent), .hfBufferCurrent(hfBufferCurrent),
    .hfReady(hfReady), .lfOscEnable(lfOscEnable), .lfActiveMode(lfActiveMode),
    .lfCrystalOn(lfCrystalOn), .lfSineBufOn(lfSineBufOn), .lfBypassOn(lfBypassOn));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // Setup then access; only the watchdog ends a wait on a stuck slave
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(err, 32'h0);
  endtask : wr

  // Oscillator pin: two cycles high, two low, slow enough for the synchroniser
  task automatic oscEdges(input int n);
    repeat (n) begin
      @(posedge clk_sys) hfOscClkPin <= 1'b1;
      idle(2);
      hfOscClkPin <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : oscEdges

  task automatic glitchPulse;
    @(posedge clk_sys) hfGlitchPin <= 1'b1;
    idle(3);
    hfGlitchPin <= 1'b0;
    idle(3);
  endtask : glitchPulse

  task automatic resetValues;
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk(rd, 32'h0000062c);
    chk(hfBoostCurrent, 32'h3);
    chk(hfBufferCurrent, 32'h1);
    chk(hfReady, 32'h0);
    chk(pready, 32'h1);
    chk({hfOscEnable, lfOscEnable}, 32'h0);
  endtask : resetValues

  task automatic badAccess;
    apb(1'b0, 12'h00c, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h00c, 32'h1);
    chk(err, 32'h1);
    apb(1'b0, `OFF_CMD, 32'h0);
    chk(rd, 32'h0);
  endtask : badAccess

  // Modes 1, 0, 2, 3: a written mode waits for the enable command; 3 selects nothing
  task automatic modeApply;
    logic [1:0] old;
    logic [1:0] mm;
    old = 2'h0;
    for (int m = 0; m < 4; m++) begin
      mm = 2'(m ^ int'(m < 2));
      wr(`OFF_CTRL, 32'h2c | (32'(mm) << 11) | 32'(mm));
      idle(3);
      chk(hfActiveMode, old);
      chk(lfActiveMode, old);
      wr(`OFF_CMD, 32'h41);
      idle(3);
      chk({hfOscEnable, lfOscEnable}, 32'h3);
      chk(hfActiveMode, mm);
      chk(lfActiveMode, mm);
      chk({hfCrystalOn, hfSineBufOn, hfBypassOn}, 3'b100 >> mm);
      chk({lfCrystalOn, lfSineBufOn, lfBypassOn}, 3'b100 >> mm);
      old = mm;
    end
    wr(`OFF_CMD, 32'h82);
    idle(3);
    chk(hfActiveMode, 32'h0);
    chk(lfActiveMode, 32'h0);
    chk(hfOscEnable, 32'h0);
    chk(lfOscEnable, 32'h0);
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk(rd, 32'h0000002c);
  endtask : modeApply

  // Every timeout code: one edge short is not ready, the last edge is
  task automatic startup;
    int n;
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 8 : (c == 1) ? 256 : (c == 2) ? 1024 : 16384;
      wr(`OFF_CTRL, 32'h2c | (32'(c) << 9));
      wr(`OFF_CMD, 32'h1);
      oscEdges(n - 1);
      idle(6);
      chk(hfReady, 32'h0);
      oscEdges(1);
      idle(6);
      chk(hfReady, 32'h1);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk(rd[1], 32'h1);
    end
  endtask : startup

  task automatic glitchRestart;
    wr(`OFF_CTRL, 32'h2c);
    wr(`OFF_CMD, 32'h1);
    oscEdges(4);
    glitchPulse();
    oscEdges(4);
    idle(6);
    chk(hfReady, 32'h1);
    wr(`OFF_CTRL, 32'hac);
    wr(`OFF_CMD, 32'h1);
    oscEdges(5);
    glitchPulse();
    oscEdges(7);
    idle(6);
    chk(hfReady, 32'h0);
    oscEdges(1);
    idle(6);
    chk(hfReady, 32'h1);
    glitchPulse();
    idle(6);
    chk(hfReady, 32'h1);
  endtask : glitchRestart

  task automatic end_of_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence after a six-cycle reset
  initial begin
    idle(6);
    sys_rst <= 1'b0;
    resetValues();
    badAccess();
    modeApply();
    glitchRestart();
    startup();
    end_of_test();
  end

  // Watchdog: the longest timeout code alone needs about 66k cycles
  initial begin
    #1000000;
    fail_count++;
    end_of_test();
  end
endmodule : osc_config_ctrl_test
